// ==== core/utxc_pkg.sv ====
// Package with register map, field positions and carrier types of the IN endpoint control block.
package utxc_pkg;

	// Register byte addresses.
	localparam logic [9:0] UTXC_EP1_LOW_OFS  = 10'h112;
	localparam logic [9:0] UTXC_EP1_HIGH_OFS = 10'h113;
	localparam logic [9:0] UTXC_EP2_HIGH_OFS = 10'h123;
	localparam logic [9:0] UTXC_EP3_HIGH_OFS = 10'h133;
	localparam logic [9:0] UTXC_INT_STAT_OFS = 10'h140;
	localparam logic [9:0] UTXC_INT_MASK_OFS = 10'h141;
	localparam logic [9:0] UTXC_MODE_OFS     = 10'h142;

	// Field positions of the low control and status register.
	localparam int UTXC_SHORTFALL_BIT = 7;
	localparam int UTXC_TOGGLE_ZERO_BIT = 6;
	localparam int UTXC_STALL_SENT_BIT = 5;
	localparam int UTXC_STALL_REQ_BIT = 4;
	localparam int UTXC_DISCARD_BIT = 3;
	localparam int UTXC_UNDERRUN_BIT = 2;
	localparam int UTXC_OCCUPIED_BIT = 1;
	localparam int UTXC_READY_BIT = 0;

	// Interrupt status bit positions.
	localparam int UTXC_IRQ_SENT_BIT = 0;
	localparam int UTXC_IRQ_DISCARD_BIT = 1;
	localparam int UTXC_IRQ_STALL_BIT = 2;
	localparam int UTXC_IRQ_UNDERRUN_BIT = 3;
	localparam int UTXC_IRQ_SHORTFALL_BIT = 4;

	// Mode register bit positions.
	localparam int UTXC_MODE_ISO_BIT = 0;
	localparam int UTXC_MODE_DOUBLE_BIT = 1;

	// Reset values and packet count constants.
	localparam logic [7:0] UTXC_LOW_RST  = 8'h00;
	localparam logic [7:0] UTXC_HIGH_RST = 8'h00;
	localparam logic [7:0] UTXC_ZERO8    = 8'h00;
	localparam logic [4:0] UTXC_IRQ_RST  = 5'h00;
	localparam logic [1:0] UTXC_CNT_ZERO = 2'h0;
	localparam logic [1:0] UTXC_CNT_TWO  = 2'h2;
	localparam logic [1:0] UTXC_CNT_ONE  = 2'h1;

	// Events reported by the USB link engine.
	typedef struct packed {
		logic in_token;
		logic pkt_sent;
		logic pkt_loaded;
		logic split_short;
	} utxc_link_type;

	// Responses to the link engine.
	typedef struct packed {
		logic send_stall;
		logic send_nak;
		logic fifo_flush;
		logic load_abort;
		logic toggle_clear;
	} utxc_resp_type;

endpackage : utxc_pkg

// ==== core/utxc_ctrl.sv ====
// IN endpoint control and status logic with register port and interrupt.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Bit 7 is set when a split isochronous packet lacked IN tokens to go out whole.
// - Writing one to bit 6 forces the data toggle to zero.
// - Sending a STALL sets bit 5, flushes the FIFO and clears packet ready.
// - While bit 4 is one, IN tokens are answered with STALL; clearing it ends that.
// - The stall request is ignored in isochronous mode.
// - Writing one to bit 3 drops the latest packet, resets the pointer, clears ready, interrupts.
// - Discard and ready written together abort the packet being loaded.
// - Bit 2 is set when an IN token that draws no STALL arrives with packet ready clear.
// - Bit 1 is set while the FIFO holds at least one packet.
// - Packet ready clears when a packet is sent, and an interrupt is raised.
// - With double buffering, ready clears when the second packet is loaded.
// - The low register of endpoint 1 is at 0x112 and resets to 0x00.
// - Endpoints 1 to 3 each have an 8-bit high control register at 0x113, 0x123, 0x133.
module utxc_ctrl
	import utxc_pkg::*;
(
	// Clock and reset.
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	// Register port.
	input  wire logic [9:0]    addr_i,
	input  wire logic [7:0]    wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output var  logic [7:0]    rdata_o,
	// Link engine.
	input  wire utxc_link_type link_i,
	output var  utxc_resp_type resp_o,
	output var  logic          toggle_o,
	// Interrupt.
	output var  logic          irq_o
);

	// Register state.
	logic [7:0]    low_reg, low_next;
	logic [7:0]    hi1_reg, hi2_reg, hi3_reg;
	logic [4:0]    ist_reg, ist_next;
	logic [4:0]    msk_reg;
	logic [1:0]    mode_reg;
	logic [1:0]    cnt_reg, cnt_next;
	logic          tog_reg, tog_next;
	logic [7:0]    rdata_reg, rdata_next;
	utxc_resp_type resp_reg, resp_next;
	logic          irq_reg;

	// Address decode.
	wire logic wr_low  = wr_i && (addr_i == UTXC_EP1_LOW_OFS);
	wire logic wr_h1   = wr_i && (addr_i == UTXC_EP1_HIGH_OFS);
	wire logic wr_h2   = wr_i && (addr_i == UTXC_EP2_HIGH_OFS);
	wire logic wr_h3   = wr_i && (addr_i == UTXC_EP3_HIGH_OFS);
	wire logic wr_ist  = wr_i && (addr_i == UTXC_INT_STAT_OFS);
	wire logic wr_msk  = wr_i && (addr_i == UTXC_INT_MASK_OFS);
	wire logic wr_mode = wr_i && (addr_i == UTXC_MODE_OFS);

	// Mode and command decode.
	wire logic iso      = mode_reg[UTXC_MODE_ISO_BIT];
	wire logic dbl      = mode_reg[UTXC_MODE_DOUBLE_BIT];
	wire logic ready    = low_reg[UTXC_READY_BIT];
	wire logic stall_on = low_reg[UTXC_STALL_REQ_BIT] && !iso;
	wire logic discard  = wr_low && wdata_i[UTXC_DISCARD_BIT];
	wire logic set_rdy  = wr_low && wdata_i[UTXC_READY_BIT];
	wire logic abort    = discard && set_rdy;
	wire logic stall_tx = link_i.in_token && stall_on;
	wire logic underrun = link_i.in_token && !stall_on && !ready;
	wire logic sent     = link_i.pkt_sent && ready && !stall_tx;
	wire logic dbl_room = dbl && link_i.pkt_loaded && (cnt_reg == UTXC_CNT_ONE);

	// Next value of the low register; hardware sets win over software clears.
	always_comb begin
		low_next = low_reg;
		if (wr_low) begin
			low_next[UTXC_SHORTFALL_BIT]  = low_reg[UTXC_SHORTFALL_BIT] & wdata_i[UTXC_SHORTFALL_BIT];
			low_next[UTXC_STALL_SENT_BIT] = low_reg[UTXC_STALL_SENT_BIT]
				& wdata_i[UTXC_STALL_SENT_BIT];
			low_next[UTXC_UNDERRUN_BIT]   = low_reg[UTXC_UNDERRUN_BIT] & wdata_i[UTXC_UNDERRUN_BIT];
			low_next[UTXC_STALL_REQ_BIT]  = wdata_i[UTXC_STALL_REQ_BIT];
			if (set_rdy && !discard) begin
				low_next[UTXC_READY_BIT] = 1'b1;
			end
		end
		if (sent || dbl_room || discard) begin
			low_next[UTXC_READY_BIT] = 1'b0;
		end
		if (stall_tx) begin
			low_next[UTXC_STALL_SENT_BIT] = 1'b1;
			low_next[UTXC_READY_BIT]      = 1'b0;
		end
		if (underrun) begin
			low_next[UTXC_UNDERRUN_BIT] = 1'b1;
		end
		if (link_i.split_short && iso) begin
			low_next[UTXC_SHORTFALL_BIT] = 1'b1;
		end
		low_next[UTXC_TOGGLE_ZERO_BIT] = 1'b0;
		low_next[UTXC_DISCARD_BIT]     = 1'b0;
		low_next[UTXC_OCCUPIED_BIT]    = (cnt_next != UTXC_CNT_ZERO);
	end

	// Packet count in the FIFO; one or two slots.
	always_comb begin
		cnt_next = cnt_reg;
		if (link_i.pkt_loaded && (cnt_reg != UTXC_CNT_TWO) && (dbl || cnt_reg == UTXC_CNT_ZERO)) begin
			cnt_next = cnt_reg + UTXC_CNT_ONE;
		end
		if (sent && cnt_reg != UTXC_CNT_ZERO) begin
			cnt_next = cnt_next - UTXC_CNT_ONE;
		end
		if (discard && cnt_reg != UTXC_CNT_ZERO) begin
			cnt_next = cnt_reg - UTXC_CNT_ONE;
		end
		if (stall_tx) begin
			cnt_next = UTXC_CNT_ZERO;
		end
	end

	// Data toggle: cleared by command, flipped on each packet sent.
	always_comb begin
		tog_next = tog_reg ^ sent;
		if (wr_low && wdata_i[UTXC_TOGGLE_ZERO_BIT]) begin
			tog_next = 1'b0;
		end
	end

	// Interrupt status: events set, writing one clears, set wins.
	wire logic [4:0] ist_set = {link_i.split_short && iso, underrun, stall_tx, discard, sent};
	always_comb begin
		ist_next = ist_reg;
		if (wr_ist) begin
			ist_next = ist_reg & ~wdata_i[4:0];
		end
		ist_next = ist_next | ist_set;
	end

	// Read data and link responses.
	always_comb begin
		unique case (addr_i)
			UTXC_EP1_LOW_OFS:  rdata_next = low_reg;
			UTXC_EP1_HIGH_OFS: rdata_next = hi1_reg;
			UTXC_EP2_HIGH_OFS: rdata_next = hi2_reg;
			UTXC_EP3_HIGH_OFS: rdata_next = hi3_reg;
			UTXC_INT_STAT_OFS: rdata_next = {3'h0, ist_reg};
			UTXC_INT_MASK_OFS: rdata_next = {3'h0, msk_reg};
			UTXC_MODE_OFS:     rdata_next = {6'h00, mode_reg};
			default:           rdata_next = UTXC_ZERO8;
		endcase
		if (!rd_i) begin
			rdata_next = UTXC_ZERO8;
		end
		resp_next.send_stall   = stall_tx;
		resp_next.send_nak     = underrun;
		resp_next.fifo_flush   = stall_tx || discard;
		resp_next.load_abort   = abort;
		resp_next.toggle_clear = wr_low && wdata_i[UTXC_TOGGLE_ZERO_BIT];
	end

	// State registers.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			low_reg   <= UTXC_LOW_RST;
			cnt_reg   <= UTXC_CNT_ZERO;
			tog_reg   <= 1'b0;
			ist_reg   <= UTXC_IRQ_RST;
			msk_reg   <= UTXC_IRQ_RST;
			mode_reg  <= 2'h0;
			rdata_reg <= UTXC_ZERO8;
			resp_reg  <= '0;
			irq_reg   <= 1'b0;
		end else begin
			low_reg   <= low_next;
			cnt_reg   <= cnt_next;
			tog_reg   <= tog_next;
			ist_reg   <= ist_next;
			msk_reg   <= wr_msk ? wdata_i[4:0] : msk_reg;
			mode_reg  <= wr_mode ? wdata_i[1:0] : mode_reg;
			rdata_reg <= rdata_next;
			resp_reg  <= resp_next;
			irq_reg   <= |(ist_next & (wr_msk ? wdata_i[4:0] : msk_reg));
		end
	end

	// High control registers, plain storage for the outside transfer logic.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			hi1_reg <= UTXC_HIGH_RST;
			hi2_reg <= UTXC_HIGH_RST;
			hi3_reg <= UTXC_HIGH_RST;
		end else begin
			hi1_reg <= wr_h1 ? wdata_i : hi1_reg;
			hi2_reg <= wr_h2 ? wdata_i : hi2_reg;
			hi3_reg <= wr_h3 ? wdata_i : hi3_reg;
		end
	end

	// Outputs straight from flip-flops.
	assign rdata_o  = rdata_reg;
	assign resp_o   = resp_reg;
	assign toggle_o = tog_reg;
	assign irq_o    = irq_reg;

	// Checks.
	stall_sets_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stall_tx |=> low_reg[UTXC_STALL_SENT_BIT] && !low_reg[UTXC_READY_BIT] && resp_o.fifo_flush)
		else $error("stall did not set flag or clear ready");
	iso_no_stall_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(iso && link_i.in_token) |=> !resp_o.send_stall)
		else $error("stall sent in isochronous mode");
	stall_req_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(link_i.in_token && low_reg[UTXC_STALL_REQ_BIT] && !iso) |=> resp_o.send_stall)
		else $error("stall request not answered");
	toggle_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && wdata_i[UTXC_TOGGLE_ZERO_BIT]) |=> !toggle_o && resp_o.toggle_clear)
		else $error("toggle not cleared");
	underrun_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		underrun |=> low_reg[UTXC_UNDERRUN_BIT])
		else $error("underrun flag not set");
	occupied_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		low_reg[UTXC_OCCUPIED_BIT] == (cnt_reg != UTXC_CNT_ZERO))
		else $error("occupied flag wrong");
	discard_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		discard |=> !low_reg[UTXC_READY_BIT] && resp_o.fifo_flush ##1 irq_o || !msk_reg[1])
		else $error("discard did not clear ready");
	abort_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		abort |=> resp_o.load_abort)
		else $error("load not aborted");
	sent_clears_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		sent |=> !low_reg[UTXC_READY_BIT] && ist_reg[UTXC_IRQ_SENT_BIT])
		else $error("ready not cleared after send");
	flag_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && wdata_i[UTXC_UNDERRUN_BIT] && low_reg[UTXC_UNDERRUN_BIT]) |=>
		low_reg[UTXC_UNDERRUN_BIT])
		else $error("flag lost on write of one");
	shortfall_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(link_i.split_short && iso) |=> low_reg[UTXC_SHORTFALL_BIT])
		else $error("shortfall flag not set");
	cover_sent_c: cover property (@(posedge mclk_i) disable iff (rst_i) sent);
	cover_stall_c: cover property (@(posedge mclk_i) disable iff (rst_i) stall_tx);
	cover_dbl_c: cover property (@(posedge mclk_i) disable iff (rst_i) dbl_room);
	cover_abort_c: cover property (@(posedge mclk_i) disable iff (rst_i) abort);
	cover_short_c: cover property (@(posedge mclk_i) disable iff (rst_i) link_i.split_short && iso);

	// Reset and register map checks.
	// Reset leaves the low register clear and the outputs quiet.
	rst_low_a: assert property (@(posedge mclk_i) rst_i |=>
		(low_reg == UTXC_LOW_RST) && !irq_o && (rdata_o == UTXC_ZERO8))
		else $error("low register not at reset value");
	// A read of the low register returns its content in the next cycle.
	read_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_i && (addr_i == UTXC_EP1_LOW_OFS)) |=> (rdata_o == $past(low_reg)))
		else $error("low register read wrong");
	// A write to the first high register stores the whole byte.
	hi1_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_h1 |=> (hi1_reg == $past(wdata_i)))
		else $error("first high register not written");
	// A write to the second high register stores the whole byte.
	hi2_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_h2 |=> (hi2_reg == $past(wdata_i)))
		else $error("second high register not written");
	// A write to the third high register stores the whole byte.
	hi3_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		wr_h3 |=> (hi3_reg == $past(wdata_i)))
		else $error("third high register not written");
	// The high registers change only through their own writes.
	high_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(wr_h1 || wr_h2 || wr_h3) |=> $stable({hi1_reg, hi2_reg, hi3_reg}))
		else $error("high register changed without a write");
	// A read of the third high register returns its content in the next cycle.
	read_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(rd_i && (addr_i == UTXC_EP3_HIGH_OFS)) |=> (rdata_o == $past(hi3_reg)))
		else $error("high register read wrong");

	// Stall and discard checks.
	// A STALL empties the packet count and drops the occupied flag.
	stall_cnt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stall_tx |=> (cnt_reg == UTXC_CNT_ZERO) && !low_reg[UTXC_OCCUPIED_BIT])
		else $error("stall did not empty the count");
	// A STALL is reported in the interrupt status.
	stall_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		stall_tx |=> ist_reg[UTXC_IRQ_STALL_BIT])
		else $error("stall not in interrupt status");
	// The flush pulse comes only from a STALL or a discard.
	flush_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(stall_tx || discard) |=> !resp_o.fifo_flush)
		else $error("flush without cause");
	// With the request bit clear an IN token never draws a STALL.
	stall_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(link_i.in_token && !low_reg[UTXC_STALL_REQ_BIT]) |=> !resp_o.send_stall)
		else $error("stall sent without request");
	// In isochronous mode an IN token without a ready packet is an underrun.
	iso_nak_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(iso && link_i.in_token && !ready) |=> resp_o.send_nak)
		else $error("isochronous token not handled as underrun");
	// A discard removes exactly one packet from the count.
	discard_cnt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(discard && (cnt_reg != UTXC_CNT_ZERO) && !stall_tx) |=>
		(cnt_reg == $past(cnt_reg) - UTXC_CNT_ONE))
		else $error("discard did not drop one packet");
	// A discard is reported in the interrupt status.
	discard_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		discard |=> ist_reg[UTXC_IRQ_DISCARD_BIT])
		else $error("discard not in interrupt status");
	// An aborted load never leaves packet ready set.
	abort_ready_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		abort |=> !low_reg[UTXC_READY_BIT])
		else $error("ready set after abort");
	// The abort pulse comes only from discard and ready written together.
	abort_only_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!abort |=> !resp_o.load_abort)
		else $error("abort without cause");

	// Flag, toggle and interrupt checks.
	// The shortfall flag rises only on a split shortfall in isochronous mode.
	shortfall_iso_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!low_reg[UTXC_SHORTFALL_BIT] && !(link_i.split_short && iso)) |=>
		!low_reg[UTXC_SHORTFALL_BIT])
		else $error("shortfall flag set without cause");
	// A shortfall is reported in the interrupt status.
	shortfall_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(link_i.split_short && iso) |=> ist_reg[UTXC_IRQ_SHORTFALL_BIT])
		else $error("shortfall not in interrupt status");
	// The toggle changes only on a packet sent or a clear command.
	toggle_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!sent && !(wr_low && wdata_i[UTXC_TOGGLE_ZERO_BIT])) |=> $stable(toggle_o))
		else $error("toggle changed without cause");
	// An underrun is reported in the interrupt status.
	underrun_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		underrun |=> ist_reg[UTXC_IRQ_UNDERRUN_BIT])
		else $error("underrun not in interrupt status");
	// A loaded packet that nothing removes leaves the FIFO occupied.
	loaded_occ_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(link_i.pkt_loaded && !stall_tx && !discard && !sent) |=> low_reg[UTXC_OCCUPIED_BIT])
		else $error("occupied flag not set after load");
	// The interrupt line follows the unmasked status bits.
	irq_level_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		irq_o == (|(ist_reg & msk_reg)))
		else $error("interrupt line does not follow status");
	// An unmasked packet sent raises the interrupt line.
	sent_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(sent && msk_reg[UTXC_IRQ_SENT_BIT] && !wr_msk) |=> irq_o)
		else $error("no interrupt after send");
	// Loading the second packet clears packet ready.
	dbl_ready_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		dbl_room |=> !low_reg[UTXC_READY_BIT])
		else $error("ready kept on second load");
	// The FIFO never counts more than two packets.
	cnt_max_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cnt_reg <= UTXC_CNT_TWO)
		else $error("packet count above two");
	// Writing one keeps the stall-sent flag.
	stall_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && wdata_i[UTXC_STALL_SENT_BIT] && low_reg[UTXC_STALL_SENT_BIT]) |=>
		low_reg[UTXC_STALL_SENT_BIT])
		else $error("stall flag lost on write of one");
	// Writing one keeps the shortfall flag.
	short_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && wdata_i[UTXC_SHORTFALL_BIT] && low_reg[UTXC_SHORTFALL_BIT]) |=>
		low_reg[UTXC_SHORTFALL_BIT])
		else $error("shortfall flag lost on write of one");
	// Writing zero clears the underrun flag unless a new underrun comes.
	under_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && !wdata_i[UTXC_UNDERRUN_BIT] && !underrun) |=> !low_reg[UTXC_UNDERRUN_BIT])
		else $error("underrun flag not cleared");
	// Writing zero clears the stall-sent flag unless a new STALL goes out.
	stall_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_low && !wdata_i[UTXC_STALL_SENT_BIT] && !stall_tx) |=>
		!low_reg[UTXC_STALL_SENT_BIT])
		else $error("stall flag not cleared");

endmodule : utxc_ctrl
`default_nettype wire

// ==== testbench/utxc_host_model.sv ====
// Behavioural host side that sends token and link events to the endpoint.
`timescale 1ns/1ns
`default_nettype none
module utxc_host_model
	import utxc_pkg::*;
(
	// Clock.
	input  wire logic          mclk_i,
	// Events towards the endpoint and its answers.
	output var  utxc_link_type link_o,
	input  wire utxc_resp_type resp_i,
	output var  logic [7:0]    stalls_o
);
	// Event word and STALL count, each written by one process only.
	utxc_link_type ev_q    = '0;
	logic [7:0]    n_stall = 8'h00;
	assign link_o   = ev_q;
	assign stalls_o = n_stall;
	// Each event is a one-cycle pulse launched just after a rising edge.
	task automatic pulse(input utxc_link_type ev);
		@(posedge mclk_i);
		ev_q <= ev;
		@(posedge mclk_i);
		ev_q <= '0;
	endtask : pulse
	// Counts the STALL handshakes the endpoint asks to be sent.
	always @(posedge mclk_i) begin
		if (resp_i.send_stall === 1'b1) n_stall <= n_stall + 8'h01;
	end
endmodule : utxc_host_model
`default_nettype wire

// ==== testbench/tb_usb_device_tx_endpoint_ctrl_status.sv ====
// Self-checking bench of the IN endpoint control and status block.
`timescale 1ns/1ns
`default_nettype none
module tb_usb_device_tx_endpoint_ctrl_status
	import utxc_pkg::*;
;
	localparam logic [9:0] LO = UTXC_EP1_LOW_OFS;
	localparam logic [9:0] ST = UTXC_INT_STAT_OFS;
	localparam logic [9:0] MD = UTXC_MODE_OFS;
	localparam utxc_link_type IN = 4'h8, SENT = 4'h4, LOAD = 4'h2, SHORT = 4'h1;
	logic          mclk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, toggle_o, irq_o;
	logic [9:0]    addr_i = 10'h000;
	logic [7:0]    wdata_i = 8'h00, rdata_o, stalls;
	logic [9:0]    hi [3] = '{UTXC_EP1_HIGH_OFS, UTXC_EP2_HIGH_OFS, UTXC_EP3_HIGH_OFS};
	utxc_link_type link_i;
	utxc_resp_type resp_o;
	int            n_errors = 0, checks = 0, cyc = 0;
	// Clock, design and host model.
	always #20 mclk_i = ~mclk_i;
	utxc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link_i(link_i), .resp_o(resp_o),
		.toggle_o(toggle_o), .irq_o(irq_o));
	utxc_host_model host (.mclk_i(mclk_i), .link_o(link_i), .resp_i(resp_o), .stalls_o(stalls));
	task automatic wrap_up;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One-cycle write and read cycles of the register port.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask : rd
	// Response pulse checked in the cycle after its cause.
	task automatic rsp(input logic [4:0] exp);
		#1 chk({3'h0, resp_o}, {3'h0, exp});
	endtask : rsp
	task automatic t_map;
		rd(LO, 8'h00);
		foreach (hi[i]) begin
			wr(hi[i], 8'hA5 ^ 8'(i));
			rd(hi[i], 8'hA5 ^ 8'(i));
		end
		rd(10'h100, 8'h00);
	endtask : t_map
	task automatic t_send;
		wr(UTXC_INT_MASK_OFS, 8'h01);
		host.pulse(LOAD);
		wr(LO, 8'h01);
		rd(LO, 8'h03);
		host.pulse(SENT);
		rd(LO, 8'h00);
		chk({7'h0, irq_o}, 8'h01);
		chk({7'h0, toggle_o}, 8'h01);
		wr(ST, 8'h01);
		rd(ST, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
		wr(LO, 8'h40);
		rsp(5'h01);
		rd(LO, 8'h00);
		chk({7'h0, toggle_o}, 8'h00);
	endtask : t_send
	task automatic t_flags;
		host.pulse(IN);
		rsp(5'h08);
		rd(LO, 8'h04);
		wr(LO, 8'h04);
		rd(LO, 8'h04);
		wr(LO, 8'h00);
		rd(LO, 8'h00);
		host.pulse(LOAD);
		wr(LO, 8'h11);
		host.pulse(IN);
		rsp(5'h14);
		rd(LO, 8'h30);
		chk(stalls, 8'h01);
		wr(LO, 8'h00);
		host.pulse(IN);
		rsp(5'h08);
		wr(MD, 8'h01);
		wr(LO, 8'h10);
		host.pulse(IN);
		rsp(5'h08);
		host.pulse(SHORT);
		rd(LO, 8'h94);
		wr(LO, 8'h00);
		wr(MD, 8'h00);
	endtask : t_flags
	task automatic t_discard;
		wr(ST, 8'h1F);
		wr(UTXC_INT_MASK_OFS, 8'h02);
		host.pulse(LOAD);
		wr(LO, 8'h01);
		wr(LO, 8'h08);
		rd(LO, 8'h00);
		rd(ST, 8'h02);
		chk({7'h0, irq_o}, 8'h01);
		host.pulse(LOAD);
		wr(LO, 8'h09);
		rsp(5'h06);
		rd(LO, 8'h00);
		wr(MD, 8'h02);
		host.pulse(LOAD);
		wr(LO, 8'h01);
		host.pulse(LOAD);
		rd(LO, 8'h02);
		wr(LO, 8'h01);
		wr(LO, 8'h08);
		rd(LO, 8'h02);
		wr(LO, 8'h01);
		wr(LO, 8'h08);
		rd(LO, 8'h00);
	endtask : t_discard
	// Cuts a hang short.
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end
	// Main sequence.
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_map();
		t_send();
		t_flags();
		t_discard();
		wrap_up();
	end
endmodule : tb_usb_device_tx_endpoint_ctrl_status
`default_nettype wire
